/* File: rtl/flash_guard_pkg.sv */
// Constants and types shared by the flash page lock guard and its lock decoder.
// Assumes a byte-addressed program flash split into equal pages.
package flash_guard_pkg;

  // ************************************************************
  // Flash geometry
  // ************************************************************
  localparam int PAGE_BYTES = 512;
  localparam int PAGE_SHIFT = 9;
  localparam int FLASH_BYTES = 8192;
  localparam int ADDR_W = 13;
  localparam int PAGE_W = ADDR_W - PAGE_SHIFT;
  localparam int LOCK_W = 8;
  localparam logic [ADDR_W-1:0] LOCK_BYTE_ADDR = 13'h1FFF;
  localparam logic [LOCK_W-1:0] LOCK_NONE = 8'hFF;

  // ************************************************************
  // Request and answer encodings
  // ************************************************************
  typedef enum logic {
    SRC_DEBUG,
    SRC_FIRMWARE
  } access_src_t;

  typedef enum logic [1:0] {
    OP_READ,
    OP_WRITE,
    OP_ERASE
  } flash_op_t;

  typedef enum logic [1:0] {
    VERDICT_PERMIT,
    VERDICT_BLOCK,
    VERDICT_ERROR_RESET
  } verdict_t;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic RESP_VALID_RST = 1'b0;
  localparam verdict_t VERDICT_RST = VERDICT_BLOCK;

endpackage : flash_guard_pkg

/* File: rtl/lock_info_if.sv */
// Carrier between the access guard and its lock decoder.
// Assumes both ends sit in the same clock domain; all signals are combinational.
`timescale 1ns/1ps
interface lock_info_if #(
  parameter int PAGE_W = flash_guard_pkg::PAGE_W,
  parameter int LOCK_W = flash_guard_pkg::LOCK_W
);
  logic [LOCK_W-1:0] lock_byte;
  logic [PAGE_W-1:0] req_page;
  logic [PAGE_W-1:0] fetch_page;
  logic req_locked;
  logic fetch_locked;
  logic any_locked;

  modport guard (
    output lock_byte,
    output req_page,
    output fetch_page,
    input req_locked,
    input fetch_locked,
    input any_locked
  );

  modport decoder (
    input lock_byte,
    input req_page,
    input fetch_page,
    output req_locked,
    output fetch_locked,
    output any_locked
  );
endinterface : lock_info_if

/* File: rtl/lock_range_decoder.sv */
// Decodes the lock byte into a locked page range and classifies two pages.
// Assumes the page numbers are already derived from byte addresses.
`timescale 1ns/1ps
module lock_range_decoder #(
  parameter int PAGE_W = flash_guard_pkg::PAGE_W,
  parameter int LOCK_W = flash_guard_pkg::LOCK_W,
  parameter logic [PAGE_W-1:0] LOCK_PAGE = '1
) (
  lock_info_if.decoder info
);

  // ************************************************************
  // Range decode
  // ************************************************************
  wire [LOCK_W-1:0] lock_count;
  wire req_in_range;
  wire fetch_in_range;

  if (PAGE_W > LOCK_W) begin : g_bad_width
    $error("Page number wider than lock count");
  end

  // Count of locked pages is the complement of the stored byte
  assign lock_count = ~info.lock_byte;
  assign info.any_locked = (lock_count != '0);
  assign req_in_range = (LOCK_W'(info.req_page) < lock_count);
  assign fetch_in_range = (LOCK_W'(info.fetch_page) < lock_count);

  // Lock page follows the others: locked as soon as any page is
  assign info.req_locked = req_in_range || ((info.req_page == LOCK_PAGE) && info.any_locked);
  assign info.fetch_locked = fetch_in_range || ((info.fetch_page == LOCK_PAGE) && info.any_locked);

endmodule : lock_range_decoder

/* File: rtl/flash_page_lock_guard.sv */
// Access guard in front of the program flash: one verdict per request.
// Assumes requests, enables, lock byte and fetch address come from logic on clk.
//
// Contract
// - Flash is split into 512-byte pages, the unit of erasure and of locking.
// - Erase and write requests are taken from both the debug port and redirected firmware stores.
// - A firmware write is refused unless the store write enable is 1.
// - A firmware erase is refused unless both store write and store erase enables are 1.
// - The first n pages from address 0 are locked, n being the complement of the lock byte.
// - The lock byte page is unlocked when the lock byte is all ones and locked otherwise.
// - Unlocked pages may be read, written and erased by the debug port and by any firmware.
// - Locked pages: debug is blocked, firmware from unlocked pages resets, firmware from locked pages passes.
// - With nothing locked the lock byte page is open to the debug port and firmware.
// - With pages locked the lock byte page is guarded exactly as the other locked pages.
`timescale 1ns/1ps
module flash_page_lock_guard #(
  parameter int ADDR_W = flash_guard_pkg::ADDR_W,
  parameter int PAGE_SHIFT = flash_guard_pkg::PAGE_SHIFT,
  parameter int LOCK_W = flash_guard_pkg::LOCK_W,
  parameter logic [flash_guard_pkg::ADDR_W-1:0] LOCK_BYTE_ADDR = flash_guard_pkg::LOCK_BYTE_ADDR
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic prog_store_write_enable,
  input wire logic prog_store_erase_enable,
  input wire logic [LOCK_W-1:0] lock_byte,
  input wire logic [ADDR_W-1:0] fetch_addr,
  input wire logic req_valid,
  input wire flash_guard_pkg::access_src_t req_src,
  input wire flash_guard_pkg::flash_op_t req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  output logic resp_valid,
  output flash_guard_pkg::verdict_t resp_verdict,
  output logic flash_access_en,
  output logic flash_error_reset
);

  localparam int PAGE_W = ADDR_W - PAGE_SHIFT;
  localparam logic [PAGE_W-1:0] LOCK_PAGE = LOCK_BYTE_ADDR[ADDR_W-1:PAGE_SHIFT];

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if ((1 << PAGE_SHIFT) != flash_guard_pkg::PAGE_BYTES) begin : g_bad_shift
    $error("Page shift does not match page size");
  end
  if (ADDR_W <= PAGE_SHIFT || PAGE_W > LOCK_W) begin : g_bad_width
    $error("Address width cannot hold pages");
  end

  // ************************************************************
  // Page decode
  // ************************************************************
  // Page number from upper bits
  function automatic logic [PAGE_W-1:0] page_of(input logic [ADDR_W-1:0] addr);
    page_of = addr[ADDR_W-1:PAGE_SHIFT];
  endfunction : page_of

  lock_info_if #(.PAGE_W(PAGE_W), .LOCK_W(LOCK_W)) info ();

  assign info.lock_byte = lock_byte;
  assign info.req_page = page_of(req_addr);
  assign info.fetch_page = page_of(fetch_addr);

  lock_range_decoder #(
    .PAGE_W(PAGE_W),
    .LOCK_W(LOCK_W),
    .LOCK_PAGE(LOCK_PAGE)
  ) i_lock_range_decoder (
    .info(info)
  );

  // ************************************************************
  // Verdict selection
  // ************************************************************
  wire is_debug;
  wire is_read;
  wire is_write;
  wire is_erase;
  wire gate_ok;
  wire target_locked;
  wire code_locked;
  flash_guard_pkg::verdict_t next_verdict;

  assign is_debug = (req_src == flash_guard_pkg::SRC_DEBUG);
  assign is_read = (req_op == flash_guard_pkg::OP_READ);
  assign is_write = (req_op == flash_guard_pkg::OP_WRITE);
  assign is_erase = (req_op == flash_guard_pkg::OP_ERASE);

  // Erase needs both enables
  // The enables guard firmware only; the debug port programs without them
  assign gate_ok = is_debug || is_read
                   || (is_write && prog_store_write_enable)
                   || (is_erase && prog_store_write_enable && prog_store_erase_enable);

  assign target_locked = info.req_locked;
  assign code_locked = info.fetch_locked;

  // Open lock page passes
  // Lock violation takes priority over the enable gate: the reset is the stronger answer
  assign next_verdict = (target_locked && is_debug) ? flash_guard_pkg::VERDICT_BLOCK :
                        (target_locked && !code_locked) ? flash_guard_pkg::VERDICT_ERROR_RESET :
                        gate_ok ? flash_guard_pkg::VERDICT_PERMIT :
                        flash_guard_pkg::VERDICT_BLOCK;

  // ************************************************************
  // Answer registers
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid <= flash_guard_pkg::RESP_VALID_RST;
      resp_verdict <= flash_guard_pkg::VERDICT_RST;
    end else begin
      resp_valid <= req_valid;
      resp_verdict <= req_valid ? next_verdict : flash_guard_pkg::VERDICT_RST;
    end
  end

  assign flash_access_en = resp_valid && (resp_verdict == flash_guard_pkg::VERDICT_PERMIT);
  assign flash_error_reset = resp_valid && (resp_verdict == flash_guard_pkg::VERDICT_ERROR_RESET);

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_fw_req;
    req_valid && !is_debug;
  endsequence

  sequence s_fw_write_no_enable;
    s_fw_req ##0 (is_write && !prog_store_write_enable && !target_locked);
  endsequence

  sequence s_fw_erase_no_enable;
    s_fw_req ##0 (is_erase && !(prog_store_write_enable && prog_store_erase_enable) && !target_locked);
  endsequence

  sequence s_fw_hits_lock_from_open;
    s_fw_req ##0 (target_locked && !code_locked);
  endsequence

  sequence s_refused_answer;
    resp_valid && !flash_access_en && !flash_error_reset;
  endsequence

  a_write_enable_gate: assert property (s_fw_write_no_enable |=> s_refused_answer)
    else $error("Firmware write passed without write enable");

  a_erase_enable_gate: assert property (s_fw_erase_no_enable |=> s_refused_answer)
    else $error("Firmware erase passed without both enables");

  a_debug_locked_block: assert property ((req_valid && is_debug && target_locked)
    |=> (resp_verdict == flash_guard_pkg::VERDICT_BLOCK) && !flash_access_en)
    else $error("Debug access to locked page not blocked");

  a_open_code_reset: assert property (s_fw_hits_lock_from_open |=> flash_error_reset ##1 !flash_error_reset
    or (flash_error_reset ##1 $past(req_valid)))
    else $error("Locked access from open code did not reset");

  a_locked_code_permit: assert property ((s_fw_req ##0 (code_locked && gate_ok)) |=> flash_access_en)
    else $error("Firmware on locked page refused");

  a_open_page_permit: assert property ((req_valid && !target_locked && gate_ok) |=> flash_access_en)
    else $error("Access to unlocked page refused");

  a_lock_page_open: assert property ((req_valid && (lock_byte == flash_guard_pkg::LOCK_NONE)
    && (page_of(req_addr) == LOCK_PAGE) && is_debug && !is_erase) |=> flash_access_en)
    else $error("Lock page refused with nothing locked");

  a_lock_page_guard: assert property ((req_valid && (lock_byte != flash_guard_pkg::LOCK_NONE)
    && (page_of(req_addr) == LOCK_PAGE) && is_debug) |=> !flash_access_en)
    else $error("Lock page open to debug while pages locked");

  a_first_page_lock: assert property ((req_addr < ADDR_W'(flash_guard_pkg::PAGE_BYTES))
    |-> (target_locked == (lock_byte != flash_guard_pkg::LOCK_NONE)))
    else $error("Page zero lock state wrong");

  // Judged from the lock byte itself, not from the decoder's summary
  a_lock_page_state: assert property ((page_of(req_addr) == LOCK_PAGE)
    |-> (target_locked == (lock_byte != flash_guard_pkg::LOCK_NONE)))
    else $error("Lock page state does not follow lock byte");

  a_one_answer: assert property (req_valid |=> resp_valid ##0 $onehot0({flash_access_en, flash_error_reset}))
    else $error("Request without single answer");

  sequence s_lock_page_req;
    req_valid && (page_of(req_addr) == LOCK_PAGE);
  endsequence

  a_idle_quiet: assert property (!resp_valid
    |-> (resp_verdict == flash_guard_pkg::VERDICT_BLOCK) && !flash_access_en && !flash_error_reset)
    else $error("Idle cycle shows an answer");

  a_no_stray_answer: assert property (!req_valid
    |=> !resp_valid)
    else $error("Answer without a request");

  a_unlocked_no_reset: assert property ((req_valid && !target_locked)
    |=> !flash_error_reset)
    else $error("Unlocked page access caused a reset");

  a_debug_never_reset: assert property ((req_valid && is_debug)
    |=> !flash_error_reset)
    else $error("Debug access caused a reset");

  a_lock_page_fw: assert property ((s_fw_req ##0 s_lock_page_req
    ##0 ((lock_byte == flash_guard_pkg::LOCK_NONE) && is_read)) |=> flash_access_en)
    else $error("Firmware read of open lock page refused");

  a_guarded_page_read: assert property ((s_fw_req ##0 s_lock_page_req
    ##0 ((lock_byte != flash_guard_pkg::LOCK_NONE) && code_locked && is_read)) |=> flash_access_en)
    else $error("Locked code refused on lock page");

  a_lock_page_reset: assert property ((s_fw_req ##0 s_lock_page_req
    ##0 ((lock_byte != flash_guard_pkg::LOCK_NONE) && !code_locked)) |=> flash_error_reset)
    else $error("Open code reached guarded lock page");

endmodule : flash_page_lock_guard

/* File: testbench/core_debug_model.sv */
// Stand-in for the processor core and the debug host that face the guard.
// Assumes its tasks are called at a falling clock edge.
`timescale 1ns/1ps
module core_debug_model (
  output logic req_valid,
  output flash_guard_pkg::access_src_t req_src,
  output flash_guard_pkg::flash_op_t req_op,
  output logic [12:0] req_addr,
  output logic [7:0] lock_byte,
  output logic [12:0] fetch_addr,
  output logic write_en,
  output logic erase_en,
  output logic rewrite_seen
);
  logic written [8192] = '{default: 1'b0};
  initial begin
    req_valid = 1'b0;
    req_src = flash_guard_pkg::SRC_DEBUG;
    req_op = flash_guard_pkg::OP_READ;
    req_addr = 13'h0000;
    lock_byte = 8'hFF;
    fetch_addr = 13'h0000;
    write_en = 1'b0;
    erase_en = 1'b0;
    rewrite_seen = 1'b0;
  end
  task automatic set_state(input logic [7:0] lb, input logic [12:0] fa, input logic we, input logic ee);
    lock_byte = lb;
    fetch_addr = fa;
    write_en = we;
    erase_en = ee;
  endtask : set_state
  task automatic issue(input flash_guard_pkg::access_src_t s, input flash_guard_pkg::flash_op_t o,
                       input logic [12:0] a);
    if (o == flash_guard_pkg::OP_WRITE && written[a]) rewrite_seen = 1'b1;
    if (o == flash_guard_pkg::OP_WRITE) written[a] = 1'b1;
    if (o == flash_guard_pkg::OP_ERASE) for (int i = 0; i < 512; i++) written[{a[12:9], 9'h000} + 13'(i)] = 1'b0;
    req_valid = 1'b1;
    req_src = s;
    req_op = o;
    req_addr = a;
  endtask : issue
  // Released address lines do not keep the last value
  task automatic idle();
    req_valid = 1'b0;
    req_addr = ~req_addr;
  endtask : idle
endmodule : core_debug_model

/* File: testbench/test_flash_page_lock_guard.sv */
// Self-checking bench for the flash page lock guard.
// Assumes the answer comes exactly one cycle after each request.
`timescale 1ns/1ps
module test_flash_page_lock_guard;
  localparam flash_guard_pkg::verdict_t PM = flash_guard_pkg::VERDICT_PERMIT;
  localparam flash_guard_pkg::verdict_t BK = flash_guard_pkg::VERDICT_BLOCK;
  localparam flash_guard_pkg::verdict_t ER = flash_guard_pkg::VERDICT_ERROR_RESET;
  localparam flash_guard_pkg::access_src_t DB = flash_guard_pkg::SRC_DEBUG;
  localparam flash_guard_pkg::access_src_t FW = flash_guard_pkg::SRC_FIRMWARE;
  localparam flash_guard_pkg::flash_op_t RD = flash_guard_pkg::OP_READ;
  localparam flash_guard_pkg::flash_op_t WR = flash_guard_pkg::OP_WRITE;
  localparam flash_guard_pkg::flash_op_t ES = flash_guard_pkg::OP_ERASE;
  logic clk = 1'b0, rst_n = 1'b0, req_valid, we, ee, resp_valid, acc_en, err_rst, rewrite_seen;
  logic [7:0] lock_byte;
  logic [12:0] fetch_addr, req_addr;
  flash_guard_pkg::access_src_t req_src;
  flash_guard_pkg::flash_op_t req_op;
  flash_guard_pkg::verdict_t resp_verdict;
  int fail_count = 0, n_tests = 0;
  core_debug_model i_core_debug_model (.req_valid(req_valid), .req_src(req_src), .req_op(req_op),
    .req_addr(req_addr), .lock_byte(lock_byte), .fetch_addr(fetch_addr), .write_en(we), .erase_en(ee),
    .rewrite_seen(rewrite_seen));
  flash_page_lock_guard i_flash_page_lock_guard (.clk(clk), .rst_n(rst_n), .prog_store_write_enable(we),
    .prog_store_erase_enable(ee), .lock_byte(lock_byte), .fetch_addr(fetch_addr), .req_valid(req_valid),
    .req_src(req_src), .req_op(req_op), .req_addr(req_addr), .resp_valid(resp_valid),
    .resp_verdict(resp_verdict), .flash_access_en(acc_en), .flash_error_reset(err_rst));
  initial forever #20 clk = ~clk;
  // ************************************************************
  // Compare and drive helpers
  // ************************************************************
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_bit
  task automatic cmp_verdict(input flash_guard_pkg::verdict_t e, input flash_guard_pkg::verdict_t g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value resp_verdict expected %0d seen %0d", e, g);
    end
  endtask : cmp_verdict
  task automatic req(input flash_guard_pkg::access_src_t s, input flash_guard_pkg::flash_op_t o,
                     input logic [12:0] a, input flash_guard_pkg::verdict_t e);
    i_core_debug_model.issue(s, o, a);
    @(negedge clk);
    cmp_bit("resp_valid", 1'b1, resp_valid);
    cmp_verdict(e, resp_verdict);
    cmp_bit("flash_access_en", e == PM, acc_en);
    cmp_bit("flash_error_reset", e == ER, err_rst);
  endtask : req
  task automatic idle_check();
    i_core_debug_model.idle();
    @(negedge clk);
    cmp_bit("resp_valid", 1'b0, resp_valid);
    cmp_verdict(BK, resp_verdict);
    cmp_bit("flash_access_en", 1'b0, acc_en);
    cmp_bit("flash_error_reset", 1'b0, err_rst);
  endtask : idle_check
  task automatic finish_test();
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic s_enables();
    i_core_debug_model.set_state(8'hFF, 13'h0100, 1'b0, 1'b0);
    req(FW, WR, 13'h0400, BK);
    req(FW, ES, 13'h0400, BK);
    req(FW, RD, 13'h0400, PM);
    req(DB, WR, 13'h0401, PM);
    i_core_debug_model.set_state(8'hFF, 13'h0100, 1'b1, 1'b0);
    req(FW, WR, 13'h0402, PM);
    req(FW, ES, 13'h0400, BK);
    i_core_debug_model.set_state(8'hFF, 13'h0100, 1'b0, 1'b1);
    req(FW, ES, 13'h0600, BK);
    i_core_debug_model.set_state(8'hFF, 13'h0100, 1'b1, 1'b1);
    req(FW, ES, 13'h0400, PM);
    idle_check();
  endtask : s_enables
  task automatic s_locked();
    i_core_debug_model.set_state(8'hFD, 13'h0400, 1'b1, 1'b1);
    req(DB, RD, 13'h03FF, BK);
    req(DB, ES, 13'h0400, PM);
    req(FW, RD, 13'h0000, ER);
    i_core_debug_model.set_state(8'hFD, 13'h0400, 1'b0, 1'b0);
    req(FW, WR, 13'h0200, ER);
    i_core_debug_model.set_state(8'hFD, 13'h0200, 1'b1, 1'b0);
    req(FW, WR, 13'h0010, PM);
    req(FW, ES, 13'h0200, BK);
    // A count beyond the page count locks every page
    i_core_debug_model.set_state(8'h00, 13'h0400, 1'b0, 1'b0);
    req(DB, RD, 13'h0A00, BK);
    req(FW, RD, 13'h0A00, PM);
    idle_check();
  endtask : s_locked
  task automatic s_lock_page();
    i_core_debug_model.set_state(8'hFF, 13'h0400, 1'b1, 1'b1);
    req(DB, WR, 13'h1FFF, PM);
    req(FW, RD, 13'h1E00, PM);
    i_core_debug_model.set_state(8'hFE, 13'h0400, 1'b1, 1'b1);
    req(DB, RD, 13'h1FFF, BK);
    req(FW, WR, 13'h1E01, ER);
    req(DB, RD, 13'h1DFF, PM);
    i_core_debug_model.set_state(8'hFE, 13'h1F00, 1'b1, 1'b1);
    req(FW, RD, 13'h1E00, PM);
    i_core_debug_model.set_state(8'hFE, 13'h0000, 1'b1, 1'b1);
    req(FW, WR, 13'h1E02, PM);
    idle_check();
  endtask : s_lock_page
  // Reset dropped while an answer stands must clear it at once
  task automatic s_reset();
    i_core_debug_model.set_state(8'hFF, 13'h0100, 1'b1, 1'b1);
    req(DB, RD, 13'h0400, PM);
    i_core_debug_model.issue(DB, RD, 13'h0400);
    @(negedge clk);
    cmp_bit("resp_valid", 1'b1, resp_valid);
    rst_n = 1'b0;
    i_core_debug_model.idle();
    #1;
    cmp_bit("resp_valid", 1'b0, resp_valid);
    cmp_verdict(BK, resp_verdict);
    cmp_bit("flash_access_en", 1'b0, acc_en);
    @(negedge clk);
    rst_n = 1'b1;
    idle_check();
  endtask : s_reset
  // Hang guard, far beyond the needed run
  initial begin
    #100us;
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    idle_check();
    s_enables();
    s_locked();
    s_lock_page();
    s_reset();
    cmp_bit("rewrite_seen", 1'b0, rewrite_seen);
    finish_test();
  end
endmodule : test_flash_page_lock_guard
